// File: logic/bcch_handler.v
`timescale 1ns/1ps
`default_nettype none
`include "bcch_map.vh"

module bcch_handler (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // serial clock pin, sampled here
  input  wire       scl,
  // received bytes from the serial framer, same clock
  input  wire       rx_valid,
  input  wire [7:0] rx_byte,
  input  wire       rx_first,
  // acknowledge decision back to the framer
  output wire       ack_own,
  output wire       ack_ok,
  // read path to the framer
  output wire [7:0] rd_value,
  output wire [1:0] rd_sel,
  // bus sequencer side
  input  wire       seq_busy,
  input  wire       seq_stat_we,
  input  wire [7:0] seq_stat,
  input  wire       seq_ptr_status,
  input  wire       seq_spu_clr,
  input  wire [7:0] seq_rd_data,
  input  wire       line_level,
  output wire       seq_abort,
  output wire       rst_done,
  // configuration outputs
  output wire       speed_select,
  output wire       strong_pullup_select,
  output wire       presence_mask_select,
  output wire       active_pullup_select
);

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_PTR  = 4'b0010;
  localparam [3:0] S_CFG  = 4'b0100;
  localparam [3:0] S_DROP = 4'b1000;

  localparam [1:0] P_STATUS = 2'h0;
  localparam [1:0] P_DATA   = 2'h1;
  localparam [1:0] P_CONFIG = 2'h2;

  localparam [2:0] A_NONE = 3'b000;
  localparam [2:0] A_RST  = 3'b001;
  localparam [2:0] A_PTR  = 3'b010;
  localparam [2:0] A_CFG  = 3'b100;

  // status bits that the bus sequencer may load; the rest stay ours
  localparam [7:0] STAT_INIT = `BCCH_STAT_RESET;
  localparam [7:0] SEQ_MASK  = (8'h01 << `BCCH_ST_PPD) | (8'h01 << `BCCH_ST_SD) | (8'h01 << `BCCH_ST_SBR)
                             | (8'h01 << `BCCH_ST_TSB) | (8'h01 << `BCCH_ST_DIR);

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [2:0] act_r;
  reg [2:0] act_nxt;
  reg [7:0] arg_r;
  reg [7:0] arg_nxt;
  reg       ack_rise_r;
  reg       rst_wait_r;
  reg       scl_s1_r;
  reg       scl_s2_r;
  reg       scl_d_r;
  reg       ll_s1_r;
  reg       ll_s2_r;
  reg [1:0] ptr_r;
  reg [3:0] cfg_r;
  wire [7:0] stat_r;
  reg       abort_r;
  reg       done_r;
  reg [7:0] rd_value_r;
  reg       own_c;
  reg       ok_c;
  reg [1:0] ptr_code;
  reg       ptr_valid;

  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire do_ptr   = ack_rise_r & scl_rise & (act_r == A_PTR);
  wire do_cfg   = ack_rise_r & scl_rise & (act_r == A_CFG);
  // reset fires on the fall that closes the ack bit; two sync stages
  // plus the edge detector keep it far inside the stop budget
  wire do_rst   = rst_wait_r & scl_fall;
  wire cfg_good = (arg_r[7:4] == ~arg_r[3:0]);

  // two-stage capture of the serial clock and the bus line level
  always @(posedge clk) begin
    if (!nrst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      ll_s1_r  <= 1'b1;
      ll_s2_r  <= 1'b1;
    end else begin
      scl_s1_r <= scl;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      ll_s1_r  <= line_level;
      ll_s2_r  <= ll_s1_r;
    end
  end

  // pointer code decode
  always @* begin
    ptr_valid = 1'b1;
    ptr_code  = P_STATUS;
    if (rx_byte == `BCCH_PTR_STATUS) begin
      ptr_code = P_STATUS;
    end else if (rx_byte == `BCCH_PTR_READ_DATA) begin
      ptr_code = P_DATA;
    end else if (rx_byte == `BCCH_PTR_CONFIG) begin
      ptr_code = P_CONFIG;
    end else begin
      ptr_valid = 1'b0;
    end
  end

  // command and parameter decode, acknowledge decision
  always @* begin
    state_nxt = state_r;
    act_nxt   = act_r;
    arg_nxt   = arg_r;
    own_c     = 1'b0;
    ok_c      = 1'b0;
    if (rx_valid && rx_first) begin
      state_nxt = S_IDLE;
      act_nxt   = A_NONE;
      if (rx_byte == `BCCH_CMD_RESET) begin
        own_c   = 1'b1;
        ok_c    = 1'b1;
        act_nxt = A_RST;
      end else if (rx_byte == `BCCH_CMD_SET_PTR) begin
        own_c     = 1'b1;
        ok_c      = 1'b1;
        state_nxt = S_PTR;
      end else if (rx_byte == `BCCH_CMD_WR_CFG) begin
        own_c = 1'b1;
        if (seq_busy) begin
          state_nxt = S_DROP;
        end else begin
          ok_c      = 1'b1;
          state_nxt = S_CFG;
        end
      end
    end else if (rx_valid) begin
      case (state_r)
        S_PTR: begin
          own_c     = 1'b1;
          ok_c      = ptr_valid;
          state_nxt = S_IDLE;
          if (ptr_valid) begin
            act_nxt = A_PTR;
            arg_nxt = {6'h00, ptr_code};
          end
        end
        S_CFG: begin
          own_c     = 1'b1;
          ok_c      = 1'b1;
          state_nxt = S_IDLE;
          act_nxt   = A_CFG;
          arg_nxt   = rx_byte;
        end
        S_DROP: begin
          own_c     = 1'b1;
          ok_c      = 1'b0;
          state_nxt = S_IDLE;
        end
        default: begin
          state_nxt = S_IDLE;
        end
      endcase
    end else if (do_ptr || do_cfg || do_rst) begin
      act_nxt = A_NONE;
    end
  end

  // command sequencing against the acknowledge bit edges
  always @(posedge clk) begin
    if (!nrst) begin
      state_r    <= S_IDLE;
      act_r      <= A_NONE;
      arg_r      <= 8'h00;
      ack_rise_r <= 1'b0;
      rst_wait_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      act_r   <= act_nxt;
      arg_r   <= arg_nxt;
      if (rx_valid) begin
        ack_rise_r <= (act_nxt != A_NONE);
        rst_wait_r <= 1'b0;
      end else if (ack_rise_r && scl_rise) begin
        ack_rise_r <= 1'b0;
        rst_wait_r <= (act_r == A_RST);
      end else if (do_rst) begin
        rst_wait_r <= 1'b0;
      end
    end
  end

  // read pointer, configuration and the reset abort and done pulses
  always @(posedge clk) begin
    if (!nrst) begin
      ptr_r   <= P_STATUS;
      cfg_r   <= `BCCH_CFG_RESET;
      abort_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      abort_r <= do_rst;
      done_r  <= abort_r;
      if (do_rst) begin
        ptr_r  <= P_STATUS;
        cfg_r  <= `BCCH_CFG_RESET;
      end else begin
        if (do_ptr) begin
          ptr_r <= arg_r[1:0];
        end else if (do_cfg && cfg_good) begin
          ptr_r <= P_CONFIG;
        end else if (seq_ptr_status) begin
          ptr_r <= P_STATUS;
        end
        if (do_cfg && cfg_good) begin
          cfg_r <= arg_r[3:0];
        end else if (seq_spu_clr) begin
          cfg_r[`BCCH_CFG_SPU] <= 1'b0;
        end
      end
    end
  end

  // status flags, one flop per bit; reset wins over a sequencer load in
  // the same cycle, and busy and line level are live so their flops idle
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat
      reg flag_r;
      always @(posedge clk) begin
        if (!nrst || do_rst) begin
          flag_r <= STAT_INIT[gi];
        end else if (gi == `BCCH_ST_RST) begin
          if (do_cfg && cfg_good) begin
            flag_r <= 1'b0;
          end
        end else if (SEQ_MASK[gi] && seq_stat_we) begin
          flag_r <= seq_stat[gi];
        end
      end
      assign stat_r[gi] = flag_r;
    end
  endgenerate

  // registered read value; busy is masked while an abort is in flight
  // so a poll right after the reset never sees a stale transfer
  always @(posedge clk) begin
    if (!nrst) begin
      rd_value_r <= `BCCH_STAT_RESET;
    end else if (ptr_r == P_CONFIG) begin
      rd_value_r <= {4'h0, cfg_r};
    end else if (ptr_r == P_DATA) begin
      rd_value_r <= seq_rd_data;
    end else begin
      rd_value_r <= {stat_r[7:5], stat_r[`BCCH_ST_RST], ll_s2_r,
                     stat_r[2:1], seq_busy & ~do_rst & ~abort_r};
    end
  end

  assign ack_own              = own_c;
  assign ack_ok               = ok_c;
  assign rd_value             = rd_value_r;
  assign rd_sel               = ptr_r;
  assign seq_abort            = abort_r;
  assign rst_done             = done_r;
  assign speed_select         = cfg_r[`BCCH_CFG_SPEED];
  assign strong_pullup_select = cfg_r[`BCCH_CFG_SPU];
  assign presence_mask_select = cfg_r[`BCCH_CFG_PPM];
  assign active_pullup_select = cfg_r[`BCCH_CFG_APU];

endmodule // bcch_handler

`default_nettype wire

// File: common/bcch_map.vh
`ifndef BCCH_MAP_VH
`define BCCH_MAP_VH
`define BCCH_CMD_RESET     8'hF0
`define BCCH_CMD_SET_PTR   8'hE1
`define BCCH_CMD_WR_CFG    8'hD2
`define BCCH_PTR_STATUS    8'hF0
`define BCCH_PTR_READ_DATA 8'hE1
`define BCCH_PTR_CONFIG    8'hC3
`define BCCH_CFG_SPEED     0
`define BCCH_CFG_SPU       1
`define BCCH_CFG_PPM       2
`define BCCH_CFG_APU       3
`define BCCH_ST_BUSY       0
`define BCCH_ST_PPD        1
`define BCCH_ST_SD         2
`define BCCH_ST_LL         3
`define BCCH_ST_RST        4
`define BCCH_ST_SBR        5
`define BCCH_ST_TSB        6
`define BCCH_ST_DIR        7
`define BCCH_CFG_RESET     4'h0
`define BCCH_STAT_RESET    8'h10
`define BCCH_CLK_PS        5000
`define BCCH_RST_DONE_PS   525000
`define BCCH_BUS_STOP_PS   262500
`define BCCH_RST_DONE_CYC  (`BCCH_RST_DONE_PS / `BCCH_CLK_PS)
`define BCCH_BUS_STOP_CYC  (`BCCH_BUS_STOP_PS / `BCCH_CLK_PS)
`endif

// File: testbench/bcch_props.sv
`timescale 1ns/1ps
`default_nettype none
module bcch_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // host bytes
  input wire logic       rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic       rx_first,
  input wire logic       ack_own,
  input wire logic       ack_ok,
  // reads and sequencer
  input wire logic [7:0] rd_value,
  input wire logic [1:0] rd_sel,
  input wire logic       seq_busy,
  input wire logic [7:0] seq_rd_data,
  input wire logic       seq_abort,
  input wire logic       rst_done,
  // configuration
  input wire logic       speed_select,
  input wire logic       strong_pullup_select,
  input wire logic       presence_mask_select,
  input wire logic       active_pullup_select
);
  wire logic [3:0] cfg = {active_pullup_select, presence_mask_select, strong_pullup_select, speed_select};
  wire logic       cmd = rx_valid && rx_first;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_abort_done: assert property (seq_abort |=> rst_done) else $error("no done after abort");
  a_abort_state: assert property (seq_abort |-> rd_sel == 2'h0 && cfg == 4'h0) else $error("state kept");
  // busy and line level are live bits, so they are masked
  a_abort_flags: assert property (seq_abort |=> (rd_value & 8'hF6) == 8'h10) else $error("bad flags");
  a_reset_ack: assert property (cmd && rx_byte == 8'hF0 |-> ack_own && ack_ok) else $error("reset nacked");
  a_busy_nack: assert property (cmd && rx_byte == 8'hD2 && seq_busy |-> !ack_ok) else $error("busy acked");
  a_cfg_ptr: assert property ($changed(cfg) && cfg != 4'h0 |-> rd_sel == 2'h2) else $error("ptr not cfg");
  a_cfg_read: assert property ((rd_sel == 2'h2)[*2] |-> rd_value == {4'h0, $past(cfg)}) else $error("cfg rd");
  a_data_read: assert property ((rd_sel == 2'h1)[*2] |-> rd_value == $past(seq_rd_data)) else $error("rd");
endmodule // bcch_props
bind bcch_handler bcch_props chk_u (.clk, .nrst, .rx_valid, .rx_byte, .rx_first, .ack_own, .ack_ok,
  .rd_value, .rd_sel, .seq_busy, .seq_rd_data, .seq_abort, .rst_done, .speed_select,
  .strong_pullup_select, .presence_mask_select, .active_pullup_select);
`default_nettype wire

// File: testbench/bcch_host.sv
`timescale 1ns/1ps
`default_nettype none
module bcch_host (
  // clock
  input  wire logic       clk,
  // handler answer
  input  wire logic       ack_own,
  input  wire logic       ack_ok,
  // serial side
  output var  logic       scl,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_first
);
  realtime t_fall;
  initial begin
    scl = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_first = 1'b0;
  end
  // one byte and its ack bit; scl stands high between bytes
  task automatic send(input logic f, input logic [7:0] b, output logic ok);
    @(negedge clk);
    scl = 1'b0;
    rx_valid = 1'b1;
    rx_byte = b;
    rx_first = f;
    @(posedge clk);
    ok = ack_own && ack_ok;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
    repeat (12) @(negedge clk);
    scl = 1'b1;
    repeat (12) @(negedge clk);
    scl = 1'b0;
    t_fall = $realtime;
    repeat (13) @(negedge clk);
    scl = 1'b1;
  endtask
endmodule // bcch_host
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk, nrst, seq_busy, ok, seq_stat_we;
  logic       scl, rx_valid, rx_first, ack_own, ack_ok, seq_abort, rst_done;
  logic [7:0] rx_byte, rd_value, seq_rd_data, seq_stat;
  logic [1:0] rd_sel;
  logic [3:0] cfg;
  int         bad_count, check_count;
  realtime    t_ab, t_dn;
  bcch_host host_u (.clk, .ack_own, .ack_ok, .scl, .rx_valid, .rx_byte, .rx_first);
  bcch_handler dut_u (.clk, .nrst, .scl, .rx_valid, .rx_byte, .rx_first, .ack_own, .ack_ok, .rd_value,
    .rd_sel, .seq_busy, .seq_stat_we, .seq_stat, .seq_ptr_status(1'b0), .seq_spu_clr(1'b0),
    .seq_rd_data, .line_level(1'b0), .seq_abort, .rst_done, .speed_select(cfg[0]),
    .strong_pullup_select(cfg[1]), .presence_mask_select(cfg[2]), .active_pullup_select(cfg[3]));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // sequencer stand-in: an abort ends the transfer
  always @(posedge clk) begin
    if (seq_abort) begin
      seq_busy <= 1'b0;
      t_ab <= $realtime;
    end
    if (rst_done) t_dn <= $realtime;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tx(input logic f, input logic [7:0] b, input logic ea);
    host_u.send(f, b, ok);
    chk({7'h00, ok}, {7'h00, ea});
    repeat (4) @(negedge clk);
  endtask
  task automatic ptr(input logic [7:0] code, input logic ea);
    tx(1'b1, 8'hE1, 1'b1);
    tx(1'b0, code, ea);
  endtask
  task automatic t_reset;
    // line level synchroniser leaves reset high and needs two edges
    repeat (2) @(negedge clk);
    chk({6'h00, rd_sel}, 8'h00);
    chk({4'h0, cfg}, 8'h00);
    chk(rd_value, 8'h10);
  endtask
  task automatic t_cfg;
    tx(1'b1, 8'hD2, 1'b1);
    tx(1'b0, 8'hA5, 1'b1);
    chk({4'h0, cfg}, 8'h05);
    chk({6'h00, rd_sel}, 8'h02);
    chk(rd_value, 8'h05);
  endtask
  task automatic t_bad;
    ptr(8'hF0, 1'b1);
    tx(1'b1, 8'hD2, 1'b1);
    tx(1'b0, 8'h55, 1'b1);
    chk({4'h0, cfg}, 8'h05);
    chk(rd_value, 8'h00);
  endtask
  task automatic t_ptr;
    logic [7:0] codes [3] = '{8'hF0, 8'hE1, 8'hC3};
    logic [7:0] reads [3] = '{8'h00, 8'h3C, 8'h05};
    for (int i = 0; i < 3; i++) begin
      ptr(codes[i], 1'b1);
      chk({6'h00, rd_sel}, 8'(i));
      chk(rd_value, reads[i]);
    end
    ptr(8'h5A, 1'b0);
    chk({6'h00, rd_sel}, 8'h02);
  endtask
  task automatic t_busy;
    seq_busy = 1'b1;
    tx(1'b1, 8'hD2, 1'b0);
    tx(1'b0, 8'h3C, 1'b0);
    chk({4'h0, cfg}, 8'h05);
    ptr(8'hF0, 1'b1);
    chk(rd_value, 8'h01);
  endtask
  task automatic t_dev;
    seq_stat = 8'hFF;
    seq_stat_we = 1'b1;
    @(negedge clk);
    seq_stat_we = 1'b0;
    repeat (2) @(negedge clk);
    chk(rd_value, 8'hE7);
    tx(1'b1, 8'hF0, 1'b1);
    repeat (105) @(negedge clk);
    chk({7'h00, t_ab > host_u.t_fall && t_ab - host_u.t_fall <= 262.5}, 8'h01);
    chk({7'h00, t_dn > host_u.t_fall && t_dn - host_u.t_fall <= 525.0}, 8'h01);
    chk({6'h00, rd_sel}, 8'h00);
    chk({4'h0, cfg}, 8'h00);
    chk(rd_value, 8'h10);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // about 19 bytes of some 215 ns each; generous margin
  initial begin
    #40us;
    bad_count++;
    wrap_up;
  end
  initial begin
    nrst = 1'b0;
    seq_busy = 1'b0;
    seq_rd_data = 8'h3C;
    seq_stat_we = 1'b0;
    seq_stat = 8'h00;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_reset;
    t_cfg;
    t_bad;
    t_ptr;
    t_busy;
    t_dev;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
